//--- rtl/wwds_pkg.sv
// constants shared by the window watchdog supervisor
package wwds_pkg;
	// reference clock
	localparam real CLK_HZ = 25000000.0;
	// timings as printed
	localparam real SHORT_TIMEOUT_S = 0.25;
	localparam real LONG_TIMEOUT_S = 2.5;
	localparam real POR_DELAY_MS = 25.0;
	localparam real CAP_STEP_PF = 15.55;
	localparam real CAP_BASE_MS = 6.25;
	// default external capacitor for the third timeout setting
	localparam real CAP_DEFAULT_PF = 1000.0;
	// window ratios, ratio-select high
	localparam real RATIO_HI_SHORT = 124.9;
	localparam real RATIO_HI_LONG = 127.7;
	localparam real RATIO_HI_CAP = 64.5;
	// window ratios, ratio-select low
	localparam real RATIO_LO_SHORT = 31.8;
	localparam real RATIO_LO_LONG = 32.0;
	localparam real RATIO_LO_CAP = 25.8;
	// derived cycle counts; timeouts are longest times, so round down
	localparam int unsigned SHORT_TIMEOUT_CYC = int'($floor(SHORT_TIMEOUT_S * CLK_HZ));
	localparam int unsigned LONG_TIMEOUT_CYC = int'($floor(LONG_TIMEOUT_S * CLK_HZ));
	localparam int unsigned CAP_TIMEOUT_CYC =
		int'($floor((CAP_DEFAULT_PF / CAP_STEP_PF + 1.0) * CAP_BASE_MS * CLK_HZ / 1000.0));
	localparam int unsigned POR_DELAY_CYC = int'($ceil(POR_DELAY_MS * CLK_HZ / 1000.0));
	// cycles the strap synchronisers need before their outputs are valid:
	// three stages plus the agree stage, plus one to read the settled copy
	localparam int unsigned SYNC_SETTLE_CYC = 5;
	// counter width
	localparam int unsigned CNT_W = 32;
	// timeout-select strap encoding
	localparam logic [1:0] TSEL_LOW = 2'h0;
	localparam logic [1:0] TSEL_HIGH = 2'h1;
	localparam logic [1:0] TSEL_CAP = 2'h2;
	// violation cause encoding
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_TIMEOUT = 2'h1;
	localparam logic [1:0] CAUSE_EARLY = 2'h2;
	// watchdog states
	typedef enum logic [1:0] {
		ST_BOOT,
		ST_RUN,
		ST_HOLD
	} wwds_state_t;
endpackage

//--- rtl/wwds_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module wwds_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and their clean copy
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_dout;

	if (WIDTH < 1) begin : g_chk
		$error("wwds_sync: WIDTH must be at least 1");
	end

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
			dout <= next_dout;
		end
	end
endmodule
`default_nettype wire

//--- rtl/wwds_top.sv
// window watchdog supervisor: trigger window checking and reset generation
//
// Overview of operation
// R1: timeout strap low gives 0.25 s, high gives 2.5 s, third code uses capacitor.
// R2: ratio strap high: lower bound is timeout over 124.9, 127.7 or 64.5.
// R3: ratio strap low: lower bound is timeout over 31.8, 32 or 25.8.
// R4: after reset release the first window checks only the upper timeout.
// R5: first rising trigger edge after release arms lower-bound checking.
// R6: processor puts every later rising edge inside the window.
// R7: processor should retrigger between worst-case lower bound and upper timeout.
// R8: edges in the tolerance bands may or may not be flagged.
// R9: capacitor timeout is (C/15.55 pF + 1) x 6.25 ms, lower bound by ratio.
// R10: rising trigger edges are taken on the next internal clock cycle; the code acts on them five cycles after the pin rises, behind the synchroniser.
// R11: reset asserts on missing trigger by timeout or early trigger when armed.
// R12: processor should vary trigger timing and not use a periodic prescaler.
// R13: each rising trigger edge restarts all watchdog timers.
// R14: after violation hold reset for the delay, then restart unarmed.
// R15: strap inputs are sampled once and held constant while running.
`timescale 1ns/1ps
`default_nettype none
module wwds_top #(
	parameter int unsigned SHORT_TIMEOUT_CYC = wwds_pkg::SHORT_TIMEOUT_CYC,
	parameter int unsigned LONG_TIMEOUT_CYC = wwds_pkg::LONG_TIMEOUT_CYC,
	parameter int unsigned CAP_TIMEOUT_CYC = wwds_pkg::CAP_TIMEOUT_CYC,
	parameter int unsigned POR_DELAY_CYC = wwds_pkg::POR_DELAY_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// strap pins
	input wire logic [1:0] timeoutSelect,
	input wire logic ratioSelect,
	// trigger pin from the supervised processor
	input wire logic triggerInput,
	// open-drain reset pin
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	// status
	output logic checkArmed,
	output logic [1:0] violationCause
);
	localparam int unsigned CW = wwds_pkg::CNT_W;

	// lower bounds are least times, so round up and keep at least one cycle
	function automatic int unsigned lowBound(input int unsigned tmo, input real ratio);
		int unsigned b;
		b = int'($ceil($itor(tmo) / ratio));
		return (b < 1) ? 1 : b;
	endfunction

	localparam logic [CW-1:0] TMO_SHORT = CW'(SHORT_TIMEOUT_CYC); // R1
	localparam logic [CW-1:0] TMO_LONG = CW'(LONG_TIMEOUT_CYC); // R1
	localparam logic [CW-1:0] TMO_CAP = CW'(CAP_TIMEOUT_CYC); // R9
	localparam logic [CW-1:0] LB_HI_SHORT = CW'(lowBound(SHORT_TIMEOUT_CYC, wwds_pkg::RATIO_HI_SHORT));
	localparam logic [CW-1:0] LB_HI_LONG = CW'(lowBound(LONG_TIMEOUT_CYC, wwds_pkg::RATIO_HI_LONG));
	localparam logic [CW-1:0] LB_HI_CAP = CW'(lowBound(CAP_TIMEOUT_CYC, wwds_pkg::RATIO_HI_CAP));
	localparam logic [CW-1:0] LB_LO_SHORT = CW'(lowBound(SHORT_TIMEOUT_CYC, wwds_pkg::RATIO_LO_SHORT));
	localparam logic [CW-1:0] LB_LO_LONG = CW'(lowBound(LONG_TIMEOUT_CYC, wwds_pkg::RATIO_LO_LONG));
	localparam logic [CW-1:0] LB_LO_CAP = CW'(lowBound(CAP_TIMEOUT_CYC, wwds_pkg::RATIO_LO_CAP));
	localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY_CYC - 1);
	localparam logic [CW-1:0] SETTLE_LAST = CW'(wwds_pkg::SYNC_SETTLE_CYC - 1);

	if (SHORT_TIMEOUT_CYC < 2 || LONG_TIMEOUT_CYC < 2 || CAP_TIMEOUT_CYC < 2) begin : g_chk_tmo
		$error("wwds_top: timeouts must be at least two cycles");
	end
	if (POR_DELAY_CYC < 1) begin : g_chk_por
		$error("wwds_top: reset hold must be at least one cycle");
	end

	// synchronised pins
	logic [3:0] syncPins;
	logic trigSync;
	logic [1:0] tselSync;
	logic rselSync;

	// watchdog state
	wwds_pkg::wwds_state_t state;
	wwds_pkg::wwds_state_t next_state;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic [1:0] cfgTsel;
	logic [1:0] next_cfgTsel;
	logic cfgRsel;
	logic next_cfgRsel;
	logic armed;
	logic next_armed;
	logic trigPrev;
	logic next_trigPrev;
	logic [1:0] cause;
	logic [1:0] next_cause;
	logic oe;
	logic next_oe;

	// selected window
	logic [CW-1:0] tmoLimit;
	logic [CW-1:0] lowLimit;
	logic trigRise;

	wwds_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.din({timeoutSelect, ratioSelect, triggerInput}),
		.dout(syncPins)
	);

	assign tselSync = syncPins[3:2];
	assign rselSync = syncPins[1];
	assign trigSync = syncPins[0];
	// edge seen on the clean copy, one cycle after it settles
	assign trigRise = trigSync & ~trigPrev; // R10

	// window limits from the latched straps
	always_comb begin
		unique case (cfgTsel)
			wwds_pkg::TSEL_LOW: begin
				tmoLimit = TMO_SHORT; // R1
				lowLimit = cfgRsel ? LB_HI_SHORT : LB_LO_SHORT; // R2 R3
			end
			wwds_pkg::TSEL_HIGH: begin
				tmoLimit = TMO_LONG; // R1
				lowLimit = cfgRsel ? LB_HI_LONG : LB_LO_LONG; // R2 R3
			end
			default: begin
				tmoLimit = TMO_CAP; // R9
				lowLimit = cfgRsel ? LB_HI_CAP : LB_LO_CAP; // R2 R3 R9
			end
		endcase
	end

	// sequencing of boot, window checking and reset hold
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_cfgTsel = cfgTsel;
		next_cfgRsel = cfgRsel;
		next_armed = armed;
		next_cause = cause;
		next_trigPrev = trigSync;
		unique case (state)
			wwds_pkg::ST_BOOT: begin
				next_armed = 1'b0; // R4
				if (cnt == SETTLE_LAST) begin
					// straps taken once, held for the whole run
					next_cfgTsel = (tselSync == wwds_pkg::TSEL_LOW || tselSync == wwds_pkg::TSEL_HIGH)
						? tselSync : wwds_pkg::TSEL_CAP; // R15
					next_cfgRsel = rselSync; // R15
					next_cnt = '0;
					next_state = wwds_pkg::ST_RUN;
				end else begin
					next_cnt = cnt + CW'(1);
				end
			end
			wwds_pkg::ST_RUN: begin
				if (trigRise && armed && cnt < lowLimit) begin
					next_cause = wwds_pkg::CAUSE_EARLY; // R11
					next_armed = 1'b0; // R14
					next_cnt = '0;
					next_state = wwds_pkg::ST_HOLD;
				end else if (trigRise) begin
					next_cnt = '0; // R13
					next_armed = 1'b1; // R5
				end else if (cnt == tmoLimit - CW'(1)) begin
					next_cause = wwds_pkg::CAUSE_TIMEOUT; // R11
					next_armed = 1'b0; // R14
					next_cnt = '0;
					next_state = wwds_pkg::ST_HOLD;
				end else begin
					next_cnt = cnt + CW'(1);
				end
			end
			wwds_pkg::ST_HOLD: begin
				next_armed = 1'b0;
				if (cnt == POR_LAST) begin
					next_cnt = '0;
					next_state = wwds_pkg::ST_BOOT; // R14
				end else begin
					next_cnt = cnt + CW'(1); // R14
				end
			end
		endcase
		// reset asserted everywhere but in the running window
		next_oe = (next_state != wwds_pkg::ST_RUN); // R11 R14
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= wwds_pkg::ST_BOOT;
			cnt <= '0;
			cfgTsel <= wwds_pkg::TSEL_LOW;
			cfgRsel <= 1'b0;
			armed <= 1'b0;
			trigPrev <= 1'b0;
			cause <= wwds_pkg::CAUSE_NONE;
			oe <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			cfgTsel <= next_cfgTsel;
			cfgRsel <= next_cfgRsel;
			armed <= next_armed;
			trigPrev <= next_trigPrev;
			cause <= next_cause;
			oe <= next_oe;
		end
	end

	// open-drain: only ever pulls low; the pin's read-back is not needed
	assign resetPinOut = 1'b0;
	assign resetPinOe = oe;
	assign checkArmed = armed;
	assign violationCause = cause;

	logic unusedPinIn;
	assign unusedPinIn = resetPinIn;
endmodule
`default_nettype wire

//--- tb/wwds_monitor.sv
// port checker for the window watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wwds_monitor #(
	parameter int unsigned SHORT_TIMEOUT_CYC = 1000,
	parameter int unsigned LONG_TIMEOUT_CYC = 4000,
	parameter int unsigned CAP_TIMEOUT_CYC = 2000,
	parameter int unsigned POR_DELAY_CYC = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pins
	input wire logic [1:0] timeoutSelect,
	input wire logic ratioSelect,
	input wire logic triggerInput,
	input wire logic resetPinIn,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	// status
	input wire logic checkArmed,
	input wire logic [1:0] violationCause
);
	logic trigPrev;
	logic [31:0] idleCnt;
	logic [31:0] oeCnt;
	logic [31:0] tLim;
	logic [1:0] tselSeen;
	logic viol;
	// strap as the block took it, while reset was still driven
	assign tLim = tselSeen[1] ? CAP_TIMEOUT_CYC :
		(tselSeen[0] ? LONG_TIMEOUT_CYC : SHORT_TIMEOUT_CYC);
	assign viol = violationCause != wwds_pkg::CAUSE_NONE;
	// cycles since last trigger rise or reset drive, and reset drive length
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trigPrev <= 1'b0;
			idleCnt <= '0;
			oeCnt <= '0;
			tselSeen <= 2'h0;
		end else begin
			tselSeen <= resetPinOe ? timeoutSelect : tselSeen;
			trigPrev <= triggerInput;
			idleCnt <= (resetPinOe || (triggerInput && !trigPrev)) ? '0 : idleCnt + 1;
			oeCnt <= resetPinOe ? oeCnt + 1 : '0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_timeout_late: assert property (!resetPinOe |-> idleCnt < tLim + 12)
		else $error("timeout missed");
	a_timeout_early: assert property ($rose(resetPinOe) && violationCause ==
		wwds_pkg::CAUSE_TIMEOUT |-> $past(idleCnt) >= tLim - 2) else $error("timeout early");
	a_cause_set: assert property ($rose(resetPinOe) |-> viol)
		else $error("no cause");
	a_early_armed: assert property ($rose(resetPinOe) && violationCause ==
		wwds_pkg::CAUSE_EARLY |-> $past(checkArmed)) else $error("early while unarmed");
	a_hold_unarmed: assert property (resetPinOe |-> !checkArmed)
		else $error("armed in reset");
	a_first_unarmed: assert property ($fell(resetPinOe) |-> !checkArmed)
		else $error("armed at start");
	a_arm_edge: assert property ($rose(checkArmed) |-> idleCnt < 12)
		else $error("armed without edge");
	a_hold_min: assert property (resetPinOe && viol && oeCnt < POR_DELAY_CYC |=> resetPinOe)
		else $error("hold short");
	a_hold_max: assert property (oeCnt <= POR_DELAY_CYC + 8)
		else $error("hold long");
endmodule
bind wwds_top wwds_monitor #(.SHORT_TIMEOUT_CYC(SHORT_TIMEOUT_CYC),
	.LONG_TIMEOUT_CYC(LONG_TIMEOUT_CYC), .CAP_TIMEOUT_CYC(CAP_TIMEOUT_CYC),
	.POR_DELAY_CYC(POR_DELAY_CYC)) u_wwds_monitor (.ref_clk, .rst_n, .timeoutSelect,
	.ratioSelect, .triggerInput, .resetPinIn, .resetPinOut, .resetPinOe, .checkArmed,
	.violationCause);
`default_nettype wire

//--- tb/wwds_proc.sv
// supervised processor model driving trigger edges
`timescale 1ns/1ps
`default_nettype none
module wwds_proc (
	// clock
	input wire logic clk,
	// trigger pin
	output logic trig
);
	initial trig = 1'b0;
	// two-cycle pulse whose rise lands spacing cycles after the previous rise
	task automatic kick(input int spacing);
		repeat (spacing - 3) @(posedge clk);
		@(posedge clk) trig <= 1'b1;
		repeat (2) @(posedge clk);
		trig <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/wwds_top_tb.sv
// self-checking bench for the window watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wwds_top_tb;
	localparam int TS = 1000;
	localparam int TL = 4000;
	localparam int TC = 2000;
	localparam int POR = 20;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] timeoutSelect = 2'h0;
	logic ratioSelect = 1'b0;
	logic triggerInput;
	logic resetPinOut, resetPinOe, checkArmed;
	logic [1:0] violationCause;
	int n_fail = 0;
	int samples_checked = 0;
	always #20 ref_clk = ~ref_clk;
	wwds_top #(.SHORT_TIMEOUT_CYC(TS), .LONG_TIMEOUT_CYC(TL), .CAP_TIMEOUT_CYC(TC),
		.POR_DELAY_CYC(POR)) u_wwds_top (.ref_clk, .rst_n, .timeoutSelect, .ratioSelect,
		.triggerInput, .resetPinIn(~resetPinOe), .resetPinOut, .resetPinOe, .checkArmed,
		.violationCause);
	wwds_proc u_wwds_proc (.clk(ref_clk), .trig(triggerInput));
	function automatic int lbnd(input int t, input real r);
		return int'($ceil(t / r));
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_oe(input logic v, input int lim, output int n);
		n = 0;
		while (resetPinOe !== v && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (resetPinOe !== v) begin
			check(resetPinOe, v);
			summarize();
		end
	endtask
	task automatic start(input logic [1:0] ts, input logic rs);
		int n;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		timeoutSelect <= ts;
		ratioSelect <= rs;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		check(resetPinOe, 1'b1);
		wait_oe(1'b0, 10, n);
		check(n, 5);
		check(resetPinOut, 1'b0);
		check({checkArmed, violationCause}, 3'h0);
	endtask
	task automatic window_case(input logic [1:0] ts, input logic rs, input int lb);
		int n;
		start(ts, rs);
		u_wwds_proc.kick(lb + 3);
		repeat (3) @(posedge ref_clk);
		#1;
		check(checkArmed, 1'b1);
		u_wwds_proc.kick(lb + 3);
		#1;
		check({resetPinOe, violationCause}, 3'h0);
		u_wwds_proc.kick(lb - 3);
		wait_oe(1'b1, 20, n);
		check(violationCause, wwds_pkg::CAUSE_EARLY);
		wait_oe(1'b0, POR + 20, n);
		check(n >= POR && n <= POR + 6, 1'b1);
		check(checkArmed, 1'b0);
	endtask
	task automatic timeout_case(input logic [1:0] ts, input int t);
		int n;
		start(ts, 1'b0);
		u_wwds_proc.kick(3);
		timeoutSelect <= ts ^ 2'h1;
		wait_oe(1'b1, t + 20, n);
		check(n >= t && n <= t + 8, 1'b1);
		check(violationCause, wwds_pkg::CAUSE_TIMEOUT);
	endtask
	initial begin
		window_case(2'h0, 1'b1, lbnd(TS, wwds_pkg::RATIO_HI_SHORT));
		window_case(2'h1, 1'b1, lbnd(TL, wwds_pkg::RATIO_HI_LONG));
		window_case(2'h2, 1'b1, lbnd(TC, wwds_pkg::RATIO_HI_CAP));
		window_case(2'h0, 1'b0, lbnd(TS, wwds_pkg::RATIO_LO_SHORT));
		window_case(2'h1, 1'b0, lbnd(TL, wwds_pkg::RATIO_LO_LONG));
		window_case(2'h3, 1'b0, lbnd(TC, wwds_pkg::RATIO_LO_CAP));
		timeout_case(2'h0, TS);
		timeout_case(2'h2, TC);
		summarize();
	end
endmodule
`default_nettype wire
